//--- design/gsg_core.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Write is address byte, then data byte
// - Serial receive line runs at 115200 baud
// - Registers are write-only, no readback path
// - Control bit 0 enables the core
// - Control bit 4 turns noise off
// - Control bit 6 turns signal off
// - Five-bit satellite select picks spreading code
// - Doppler byte sets oscillator frequency
// - Code phase from low and high bytes
// - Three-bit shift lowers signal before noise
// - Core has code generator, oscillator, noise
// - Message input modulates signal with code
// - Generated output is a single bit
module gsg_core
  import gsg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic rx_in,
  input wire logic msg_in,
  output logic sin_out,
  output logic cos_out,
  output logic noise_start_out,
  output logic start_out
);

  typedef enum logic {LD_ADDR, LD_DATA} gsg_ld_st_t;

  typedef struct packed {
    gsg_ld_st_t ld;
    logic [7:0] addr;
    gsg_cfg_t cfg;
    logic [1:0][7:0] fb;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic [31:0] carr;
    logic [31:0] chip;
    logic [9:0] g1;
    logic [9:0] g2;
    logic [9:0] chip_cnt;
    logic [15:0] nz1;
    logic [15:0] nz2;
    logic [2:0] msg_s;
    logic msg_lvl;
    logic sin;
    logic cos;
    logic nstart;
    logic start;
  } gsg_state_t;

  gsg_state_t s_q, s_d;
  logic rx_valid;
  logic rx_ready;
  gsg_byte_t rx_byte;

  // Fibonacci step shared by all four shift registers
  function automatic logic [15:0] lfsr_step(input logic [15:0] v, input logic [15:0] taps);
    lfsr_step = {v[14:0], ^(v & taps)};
  endfunction : lfsr_step

  // Two second-register taps per satellite; 32 distinct pairs
  function automatic logic [7:0] sat_taps(input logic [4:0] sat);
    logic [3:0] a;
    logic [3:0] b;
    a = 4'(sat % 5'd10);
    b = 4'((5'(a) + 5'(sat / 5'd10) + 5'd1) % 5'd10);
    sat_taps = {a, b};
  endfunction : sat_taps

  gsg_uart_rx u_rx (
    .sys_clk(sys_clk),
    .reset(reset),
    .rx_in(rx_in),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_byte(rx_byte)
  );

  logic en;
  logic noise_off;
  logic sig_off;
  logic chip_tick;
  logic drain;
  logic [32:0] chip_sum;
  logic [31:0] inc;
  logic [7:0] taps;
  logic code;
  logic [7:0] amp;
  logic [8:0] sig;
  logic [8:0] noise;
  logic [8:0] total;
  logic [7:0] b;
  logic [15:0] g1_n;
  logic [15:0] g2_n;

  assign rx_ready = (s_q.cnt != 2'd2);

  always_comb begin
    s_d = s_q;
    en = s_q.cfg.ctrl[CTRL_EN_BIT];
    noise_off = s_q.cfg.ctrl[CTRL_NOISE_OFF_BIT];
    sig_off = s_q.cfg.ctrl[CTRL_SIG_OFF_BIT];
    chip_sum = {1'b0, s_q.chip} + {1'b0, CHIP_INC};
    chip_tick = en && chip_sum[32];
    // Config changes land on chip boundaries so a chip never mixes two settings
    drain = (s_q.cnt != 2'd0) && (chip_tick || !en);
    b = s_q.fb[s_q.rp];
    inc = INC_BASE + 32'(INC_STEP * 32'(s_q.cfg.dop));
    taps = sat_taps(s_q.cfg.sat);
    code = s_q.g1[9] ^ s_q.g2[taps[7:4]] ^ s_q.g2[taps[3:0]];
    amp = SIG_AMP >> s_q.cfg.snr;
    sig = 9'h000;
    noise = 9'h000;
    // Padded to the shared step width; only the low ten bits are kept
    g1_n = lfsr_step({6'h00, s_q.g1}, {6'h00, G1_TAPS});
    g2_n = lfsr_step({6'h00, s_q.g2}, {6'h00, G2_TAPS});

    s_d.msg_s = {s_q.msg_s[1:0], msg_in};
    if (s_q.msg_s[1] == s_q.msg_s[2]) begin
      s_d.msg_lvl = s_q.msg_s[2];
    end

    if (rx_valid && rx_ready) begin
      s_d.fb[s_q.wp] = rx_byte.data;
      s_d.wp = ~s_q.wp;
    end
    if (drain) begin
      s_d.rp = ~s_q.rp;
      case (s_q.ld)
        LD_ADDR: begin
          s_d.addr = b;
          s_d.ld = LD_DATA;
        end
        LD_DATA: begin
          s_d.ld = LD_ADDR;
          case (s_q.addr)
            ADDR_CTRL: s_d.cfg.ctrl = b;
            ADDR_SAT: s_d.cfg.sat = b[4:0];
            ADDR_DOP: s_d.cfg.dop = b;
            ADDR_PH_LO: s_d.cfg.phase[7:0] = b;
            ADDR_PH_HI: s_d.cfg.phase[15:8] = b;
            ADDR_SNR: s_d.cfg.snr = b[2:0];
            default: s_d.cfg = s_q.cfg;
          endcase
        end
        default: s_d.ld = LD_ADDR;
      endcase
    end
    s_d.cnt = s_q.cnt + 2'((rx_valid && rx_ready) ? 1 : 0) - 2'(drain ? 1 : 0);

    if (en) begin
      s_d.carr = s_q.carr + inc;
      s_d.chip = chip_sum[31:0];
      if (chip_tick) begin
        if (s_q.chip_cnt == CODE_LAST) begin
          s_d.chip_cnt = 10'h000;
          s_d.g1 = G_SEED;
          s_d.g2 = G_SEED;
        end else begin
          s_d.chip_cnt = s_q.chip_cnt + 10'h001;
          s_d.g1 = g1_n[9:0];
          s_d.g2 = g2_n[9:0];
        end
      end
      s_d.nz1 = lfsr_step(s_q.nz1, NZ1_TAPS);
      s_d.nz2 = lfsr_step(s_q.nz2, NZ2_TAPS);
      if (!sig_off) begin
        // Carrier sign flipped by code and message
        sig = (~s_q.carr[31] ^ code ^ s_q.msg_lvl) ? {1'b0, amp} : -{1'b0, amp};
      end
      if (!noise_off) begin
        noise = {s_q.nz1[7], s_q.nz1[7:0] ^ s_q.nz2[15:8]};
      end
    end else begin
      // Disabled: all generators parked at their seeds
      s_d.carr = 32'h0000_0000;
      s_d.chip = 32'h0000_0000;
      s_d.chip_cnt = 10'h000;
      s_d.g1 = G_SEED;
      s_d.g2 = G_SEED;
      s_d.nz1 = NZ1_SEED;
      s_d.nz2 = NZ2_SEED;
    end
    total = sig + noise;
    s_d.sin = en && !total[8] && (total != 9'h000 || !sig_off);
    s_d.cos = en && !sig_off &&
              (~(s_q.carr[31] ^ s_q.carr[30]) ^ code ^ s_q.msg_lvl);
    s_d.start = en && ({6'h00, s_q.chip_cnt} == s_q.cfg.phase);
    s_d.nstart = en && (s_q.nz1 == NZ1_SEED);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '{ld: LD_ADDR, addr: 8'h00, cfg: '0, fb: '0, wp: 1'b0, rp: 1'b0,
               cnt: 2'd0, carr: 32'h0000_0000, chip: 32'h0000_0000, g1: G_SEED,
               g2: G_SEED, chip_cnt: 10'h000, nz1: NZ1_SEED, nz2: NZ2_SEED,
               msg_s: 3'h0, msg_lvl: 1'b0, sin: 1'b0, cos: 1'b0, nstart: 1'b0,
               start: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sin_out = s_q.sin;
  assign cos_out = s_q.cos;
  assign noise_start_out = s_q.nstart;
  assign start_out = s_q.start;

endmodule : gsg_core
`default_nettype wire

//--- design/gsg_pkg.sv
package gsg_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_RATE = 115200;
  // Nearest whole count; the error stays well inside a UART's tolerance
  localparam int BAUD_CYC = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int HALF_CYC = BAUD_CYC / 2;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SAT = 8'h02;
  localparam logic [7:0] ADDR_DOP = 8'h03;
  localparam logic [7:0] ADDR_PH_LO = 8'h04;
  localparam logic [7:0] ADDR_PH_HI = 8'h05;
  localparam logic [7:0] ADDR_SNR = 8'h06;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_NOISE_OFF_BIT = 4;
  localparam int CTRL_SIG_OFF_BIT = 6;

  localparam longint F_CENTER_HZ = 64'd4092000;
  localparam longint F_OFFSET_HZ = 64'd8000;
  localparam longint F_STEP_HZ = 64'd500;
  localparam longint DOP_ZERO = 64'd176;
  localparam longint F_BASE_HZ = F_CENTER_HZ - F_OFFSET_HZ - F_STEP_HZ * DOP_ZERO;
  localparam logic [31:0] INC_BASE = 32'((F_BASE_HZ << 32) / CLK_HZ);
  localparam logic [31:0] INC_STEP = 32'((F_STEP_HZ << 32) / CLK_HZ);
  localparam longint CHIP_HZ = 64'd1023000;
  localparam logic [31:0] CHIP_INC = 32'((CHIP_HZ << 32) / CLK_HZ);

  localparam logic [9:0] CODE_LAST = 10'h3FE;
  localparam logic [9:0] G_SEED = 10'h3FF;
  localparam logic [9:0] G1_TAPS = 10'h204;
  localparam logic [9:0] G2_TAPS = 10'h3A6;
  localparam logic [15:0] NZ1_SEED = 16'hACE1;
  localparam logic [15:0] NZ2_SEED = 16'h5A3C;
  localparam logic [15:0] NZ1_TAPS = 16'hB400;
  localparam logic [15:0] NZ2_TAPS = 16'hD008;
  localparam logic [7:0] SIG_AMP = 8'h40;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [4:0] sat;
    logic [7:0] dop;
    logic [15:0] phase;
    logic [2:0] snr;
  } gsg_cfg_t;

  typedef struct packed {
    logic [7:0] data;
  } gsg_byte_t;

endpackage : gsg_pkg

//--- design/gsg_uart_rx.sv
`timescale 1ns/1ns
`default_nettype none
module gsg_uart_rx
  import gsg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic rx_in,
  output logic out_valid,
  input wire logic out_ready,
  output gsg_byte_t out_byte
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} gsg_rx_st_t;

  typedef struct packed {
    logic [2:0] sync;
    logic line;
    gsg_rx_st_t st;
    logic [15:0] cnt;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic valid;
    gsg_byte_t data;
  } gsg_rx_state_t;

  gsg_rx_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], rx_in};
    // Level only moves once the last two stages agree
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.line = s_q.sync[2];
    end
    if (s_q.valid && out_ready) begin
      s_d.valid = 1'b0;
    end
    case (s_q.st)
      RX_IDLE: begin
        if (!s_q.line) begin
          s_d.st = RX_START;
          s_d.cnt = 16'(HALF_CYC - 1);
        end
      end
      RX_START: begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else if (s_q.line) begin
          s_d.st = RX_IDLE; // Glitch, not a start bit
        end else begin
          s_d.st = RX_BITS;
          s_d.cnt = 16'(BAUD_CYC - 1);
          s_d.bitn = 3'h0;
        end
      end
      RX_BITS: begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          s_d.sh = {s_q.line, s_q.sh[7:1]};
          s_d.cnt = 16'(BAUD_CYC - 1);
          s_d.bitn = s_q.bitn + 3'h1;
          if (s_q.bitn == 3'h7) begin
            s_d.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          s_d.st = RX_IDLE;
          // Framing errors and overruns drop the byte; held data is never overwritten
          if (s_q.line && !s_d.valid) begin
            s_d.valid = 1'b1;
            s_d.data.data = s_q.sh;
          end
        end
      end
      default: s_d.st = RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '{sync: 3'h7, line: 1'b1, st: RX_IDLE, cnt: 16'h0000, bitn: 3'h0,
               sh: 8'h00, valid: 1'b0, data: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign out_valid = s_q.valid;
  assign out_byte = s_q.data;

endmodule : gsg_uart_rx
`default_nettype wire

//--- tb/gsg_core_chk.sv
`timescale 1ns/1ns
`default_nettype none
module gsg_core_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic rx_in,
  input wire logic msg_in,
  input wire logic sin_out,
  input wire logic cos_out,
  input wire logic noise_start_out,
  input wire logic start_out
);
  logic [11:0] cyc_q;
  logic [1:0] fall_q;
  logic [4:0] hi_q;
  logic rx_q;
  // Saturating counters keep the idle checks valid for a whole run
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cyc_q <= 12'h000;
      fall_q <= 2'h0;
      hi_q <= 5'h00;
      rx_q <= 1'b1;
    end else begin
      rx_q <= rx_in;
      if (cyc_q != 12'hFFF) cyc_q <= cyc_q + 12'h001;
      if (rx_q && !rx_in && fall_q != 2'h2) fall_q <= fall_q + 2'h1;
      hi_q <= !start_out ? 5'h00 : (hi_q == 5'h1F ? hi_q : hi_q + 5'h01);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_reset_clears: assert property (disable iff (1'b0)
    reset |=> !(sin_out | cos_out | start_out | noise_start_out))
    else $error("outputs active after reset");
  a_one_byte_idle: assert property (fall_q < 2'h2 |-> !sin_out && !cos_out)
    else $error("output before a whole write");
  a_baud_idle: assert property (cyc_q < 12'hF3C |-> !start_out && !noise_start_out)
    else $error("marker before two frames could end");
  a_noise_pulse: assert property (noise_start_out |=> !noise_start_out)
    else $error("noise start longer than one cycle");
  a_start_hold: assert property ($rose(start_out) |-> start_out [*8])
    else $error("start marker shorter than a chip");
  a_start_max: assert property (hi_q <= 5'h1A)
    else $error("start marker longer than a chip");
  a_msg_no_cfg: assert property ($changed(msg_in) && fall_q == 2'h0 |=> $stable(cos_out) [*4])
    else $error("message input changed idle output");
  a_release_idle: assert property ($fell(reset) |-> !sin_out [*8])
    else $error("sine active after reset release");

  c_start: cover property ($rose(start_out));
  c_noise: cover property (noise_start_out);
  c_sin: cover property ($rose(sin_out));
endmodule : gsg_core_chk

bind gsg_core gsg_core_chk u_chk (.sys_clk(sys_clk), .reset(reset), .rx_in(rx_in),
  .msg_in(msg_in), .sin_out(sin_out), .cos_out(cos_out),
  .noise_start_out(noise_start_out), .start_out(start_out));
`default_nettype wire

//--- tb/gsg_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module gsg_core_tb;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic msg;
    logic [1:0] seen;
  } gsg_row_t;

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic msg_in = 1'b0;
  wire logic rx_in;
  logic sin_out, cos_out, noise_start_out, start_out;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Expected {sine, cosine} activity over a window after each write
  gsg_row_t rows [6] = '{
    '{8'h01, 8'h01, 1'b1, 2'b00},
    '{8'h00, 8'h50, 1'b0, 2'b00},
    '{8'h00, 8'h51, 1'b0, 2'b00},
    '{8'h00, 8'h41, 1'b0, 2'b10},
    '{8'h00, 8'h11, 1'b1, 2'b11},
    '{8'h00, 8'h00, 1'b0, 2'b00}};

  gsg_core u_dut (.sys_clk(sys_clk), .reset(reset), .rx_in(rx_in), .msg_in(msg_in),
    .sin_out(sin_out), .cos_out(cos_out), .noise_start_out(noise_start_out),
    .start_out(start_out));
  gsg_host u_host (.sys_clk(sys_clk), .rx_in(rx_in));

  always #20 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %b expected %b", $time, what, seen, exp);
    end
  endtask : chk

  // OR of {sin, cos, start, noise start} over n cycles
  task automatic watch(input int n, output logic [3:0] seen);
    seen = 4'h0;
    repeat (n) begin
      @(posedge sys_clk);
      seen = seen | {sin_out, cos_out, start_out, noise_start_out};
    end
  endtask : watch

  initial begin
    logic [3:0] seen;
    int wait_n;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    foreach (rows[i]) begin
      msg_in <= rows[i].msg;
      u_host.write_reg(rows[i].addr, rows[i].data, 0);
      repeat (40) @(posedge sys_clk);
      watch(256, seen);
      chk({2'h0, seen[3:2]}, {2'h0, rows[i].seen}, "row");
    end
    // Phase 0x0100 needs both bytes in the right halves; slow host here
    u_host.write_reg(8'h04, 8'h00, 0);
    u_host.write_reg(8'h05, 8'h01, 500);
    u_host.write_reg(8'h00, 8'h11, 0);
    wait_n = 0;
    while (start_out !== 1'b1 && wait_n < 8000) begin
      @(posedge sys_clk);
      wait_n++;
    end
    chk({3'h0, wait_n > 5800 && wait_n < 6400}, 4'h1, "phase delay");
    // Reset in mid-run returns the core to disabled
    reset <= 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    watch(300, seen);
    chk(seen, 4'h0, "after reset");
    print_verdict();
  end
endmodule : gsg_core_tb
`default_nettype wire

//--- tb/gsg_host.sv
`timescale 1ns/1ns
`default_nettype none
module gsg_host
  import gsg_pkg::*;
(
  input wire logic sys_clk,
  output logic rx_in
);
  // Idle line rests high between frames
  initial rx_in = 1'b1;

  task automatic put_byte(input logic [7:0] b, input int gap);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_in <= frame[i]; // LSB first, one bit per baud period
      repeat (BAUD_CYC) @(posedge sys_clk);
    end
    repeat (gap) @(posedge sys_clk);
  endtask : put_byte

  // Gap lets the host answer slowly as well as back to back
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input int gap);
    put_byte(a, gap); // Address byte goes first
    put_byte(d, gap); // Data byte follows it
  endtask : write_reg
endmodule : gsg_host
`default_nettype wire
